// File: rtl/cluster_bus_master_arbiter.sv
// cluster bus multiplexer with sequencer bus master front end
// assumes cpu and sequencer logic share mclk; targets sampled on completion
//
// Overview of operation
// - the multiplexer arbitrates the bus between cpu and sequencer, sequencer first.
// - an access takes one bus cycle for zero wait, two for one wait, more beyond.
// - ordinary registers and sequencer converter reads finish with zero wait.
// - reset, clock configuration, output global control and second pll control take one wait.
// - memories, fifo windows and trigger set and clear registers take two waits.
// - fifo memory and sequencer memory are refused to the sequencer master port.
// - the sequencer master buffers requests stalled by cpu or multi-cycle accesses.
// - converter requests arrive on the same port and are routed by address to the converter.
// - converter accesses take zero wait and never pass through the buffers.
// - stream routing traffic is outside this arbiter and never waits on it.
// - once a delaying cpu access completes, the buffered sequencer access runs next.
`timescale 1ns/1ps
`default_nettype none
module cluster_bus_master_arbiter
	import cluster_bus_pkg::*;
(
	input wire logic mclk,
	input wire logic resetn,
	input wire logic sequencer_master_disable,
	input wire logic cpu_req,
	input wire cluster_bus_pkg::bus_req_t cpu_cmd,
	output logic cpu_done,
	output logic [cluster_bus_pkg::DATA_W-1:0] cpu_rdata,
	input wire logic seq_valid,
	input wire cluster_bus_pkg::bus_req_t seq_cmd,
	output logic seq_ready,
	output logic seq_resp_valid,
	output logic seq_resp_err,
	output logic [cluster_bus_pkg::DATA_W-1:0] seq_resp_rdata,
	output logic seq_adc_valid,
	output logic [cluster_bus_pkg::DATA_W-1:0] seq_adc_rdata,
	output logic bus_sel,
	output cluster_bus_pkg::bus_req_t bus_cmd,
	input wire logic [cluster_bus_pkg::DATA_W-1:0] bus_rdata,
	output logic adc_sel,
	output logic [cluster_bus_pkg::ADDR_W-1:0] adc_addr,
	input wire logic [cluster_bus_pkg::DATA_W-1:0] adc_rdata
);
	import cluster_bus_pkg::*;

	typedef enum logic {ST_IDLE, ST_BUSY} arb_state_t;

	arb_state_t state_reg, state_next;
	logic owner_seq_reg, owner_seq_next;
	logic refuse_reg, refuse_next;
	logic [CNT_W-1:0] cnt_reg, cnt_next;
	bus_req_t cmd_reg, cmd_next;
	logic sel_reg, sel_next;
	logic cpu_done_reg, cpu_done_next;
	logic [DATA_W-1:0] cpu_rdata_reg, cpu_rdata_next;
	logic sresp_reg, sresp_next;
	logic serr_reg, serr_next;
	logic [DATA_W-1:0] srdata_reg, srdata_next;
	logic adc_sel_reg, adc_sel_next;
	logic [ADDR_W-1:0] adc_addr_reg, adc_addr_next;
	logic adc_resp_reg, adc_resp_next;
	logic [DATA_W-1:0] adc_rdata_reg, adc_rdata_next;

	logic buf_in_valid, buf_ready, buf_valid, buf_pop;
	bus_req_t buf_head;
	logic seq_is_adc, grant, grant_seq, finish;
	access_class_t grant_cls;

	// ----------------------------------------------------------
	// entry stage: converter requests split off ahead of the buffer
	// ----------------------------------------------------------
	// converter requests are taken on valid with sequencer_master_disable low, without waiting for ready: they never stall
	assign seq_is_adc = (classify(seq_cmd.addr) == CLS_ADC);
	assign buf_in_valid = seq_valid && !seq_is_adc;

	// stalled bus requests wait here; depth two covers one stalled
	// request plus the one behind it, so keep traffic light
	sequencer_master_buffer u_buf (
		.mclk(mclk),
		.resetn(resetn),
		.in_valid(buf_in_valid),
		.in_data(seq_cmd),
		.in_block(sequencer_master_disable),
		.in_ready(buf_ready),
		.out_valid(buf_valid),
		.out_data(buf_head),
		.out_pop(buf_pop)
	);

	// ----------------------------------------------------------
	// converter path, zero wait, registered straight through
	// ----------------------------------------------------------
	always_comb begin
		adc_sel_next = seq_valid && seq_is_adc &&
		    !sequencer_master_disable;
		adc_addr_next = adc_sel_next ? seq_cmd.addr : adc_addr_reg;
		adc_resp_next = adc_sel_reg;
		adc_rdata_next = adc_sel_reg ? adc_rdata : adc_rdata_reg;
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			adc_sel_reg <= 1'b0;
			adc_addr_reg <= '0;
			adc_resp_reg <= 1'b0;
			adc_rdata_reg <= '0;
		end else begin
			adc_sel_reg <= adc_sel_next;
			adc_addr_reg <= adc_addr_next;
			adc_resp_reg <= adc_resp_next;
			adc_rdata_reg <= adc_rdata_next;
		end
	end

	// ----------------------------------------------------------
	// arbiter: grant, wait count and completion
	// ----------------------------------------------------------
	// stream routing transfers have no path through here at all
	always_comb begin
		// cpu_done_reg guard: the cpu still holds req in its done cycle
		grant_seq = (state_reg == ST_IDLE) && buf_valid;
		grant = grant_seq || ((state_reg == ST_IDLE) && cpu_req &&
		    !cpu_done_reg);
		grant_cls = classify(grant_seq ? buf_head.addr : cpu_cmd.addr);
		finish = (state_reg == ST_BUSY) && (cnt_reg == WAIT_N0);
		buf_pop = grant_seq;
		state_next = state_reg;
		owner_seq_next = owner_seq_reg;
		refuse_next = refuse_reg;
		cnt_next = cnt_reg;
		cmd_next = cmd_reg;
		sel_next = sel_reg;
		cpu_done_next = 1'b0;
		cpu_rdata_next = cpu_rdata_reg;
		sresp_next = 1'b0;
		serr_next = 1'b0;
		srdata_next = srdata_reg;
		unique case (state_reg)
			ST_IDLE: begin
				if (grant) begin
					state_next = ST_BUSY;
					owner_seq_next = grant_seq;
					cmd_next = grant_seq ? buf_head : cpu_cmd;
					refuse_next = grant_seq &&
					    seq_forbidden(buf_head.addr);
					cnt_next = refuse_next ? WAIT_N0 :
					    wait_of(grant_cls);
					sel_next = !refuse_next;
				end
			end
			ST_BUSY: begin
				// no grant while busy: the access runs out first
				if (finish) begin
					state_next = ST_IDLE;
					sel_next = 1'b0;
					if (owner_seq_reg) begin
						sresp_next = 1'b1;
						serr_next = refuse_reg;
						srdata_next = refuse_reg ? '0 : bus_rdata;
					end else begin
						cpu_done_next = 1'b1;
						cpu_rdata_next = bus_rdata;
					end
				end else begin
					cnt_next = cnt_reg - 4'h1;
				end
			end
		endcase
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			state_reg <= ST_IDLE;
			owner_seq_reg <= 1'b0;
			refuse_reg <= 1'b0;
			cnt_reg <= WAIT_N0;
			cmd_reg <= '0;
			sel_reg <= 1'b0;
			cpu_done_reg <= 1'b0;
			cpu_rdata_reg <= '0;
			sresp_reg <= 1'b0;
			serr_reg <= 1'b0;
			srdata_reg <= '0;
		end else begin
			state_reg <= state_next;
			owner_seq_reg <= owner_seq_next;
			refuse_reg <= refuse_next;
			cnt_reg <= cnt_next;
			cmd_reg <= cmd_next;
			sel_reg <= sel_next;
			cpu_done_reg <= cpu_done_next;
			cpu_rdata_reg <= cpu_rdata_next;
			sresp_reg <= sresp_next;
			serr_reg <= serr_next;
			srdata_reg <= srdata_next;
		end
	end

	// ----------------------------------------------------------
	// outputs
	// ----------------------------------------------------------
	assign seq_ready = buf_ready;
	assign cpu_done = cpu_done_reg;
	assign cpu_rdata = cpu_rdata_reg;
	assign seq_resp_valid = sresp_reg;
	assign seq_resp_err = serr_reg;
	assign seq_resp_rdata = srdata_reg;
	assign seq_adc_valid = adc_resp_reg;
	assign seq_adc_rdata = adc_rdata_reg;
	assign bus_sel = sel_reg;
	assign bus_cmd = cmd_reg;
	assign adc_sel = adc_sel_reg;
	assign adc_addr = adc_addr_reg;

	// ----------------------------------------------------------
	// checks
	// ----------------------------------------------------------
	property p_seq_first;
		@(posedge mclk) disable iff (!resetn)
		(state_reg == ST_IDLE && buf_valid && cpu_req) |=>
		    (state_reg == ST_BUSY && owner_seq_reg);
	endproperty
	a_seq_first: assert property (p_seq_first)
		else $error("cpu granted over pending sequencer request");

	property p_zero_wait;
		@(posedge mclk) disable iff (!resetn)
		(grant && !refuse_next && grant_cls == CLS_N0) |=>
		    bus_sel ##1 (!bus_sel && (cpu_done || seq_resp_valid));
	endproperty
	a_zero_wait: assert property (p_zero_wait)
		else $error("zero-wait access not one bus cycle");

	property p_one_wait;
		@(posedge mclk) disable iff (!resetn)
		(grant && !refuse_next && grant_cls == CLS_N1) |=>
		    bus_sel[*2] ##1 !bus_sel;
	endproperty
	a_one_wait: assert property (p_one_wait)
		else $error("one-wait access not two bus cycles");

	property p_multi_wait;
		@(posedge mclk) disable iff (!resetn)
		(grant && !refuse_next && grant_cls == CLS_MEM) |=>
		    bus_sel[*3] ##1 !bus_sel;
	endproperty
	a_multi_wait: assert property (p_multi_wait)
		else $error("memory access not three bus cycles");

	property p_refuse;
		@(posedge mclk) disable iff (!resetn)
		(grant_seq && seq_forbidden(buf_head.addr)) |=>
		    !bus_sel ##1 (seq_resp_valid && seq_resp_err);
	endproperty
	a_refuse: assert property (p_refuse)
		else $error("sequencer reached a forbidden memory");

	property p_buffered;
		@(posedge mclk) disable iff (!resetn)
		(state_reg == ST_BUSY && buf_in_valid && seq_ready) |=>
		    buf_valid;
	endproperty
	a_buffered: assert property (p_buffered)
		else $error("stalled sequencer request not buffered");

	property p_adc_bypass;
		@(posedge mclk) disable iff (!resetn)
		(seq_valid && seq_is_adc && !sequencer_master_disable) |=>
		    adc_sel && adc_addr == $past(seq_cmd.addr) &&
		    !$rose(buf_valid) ##1 seq_adc_valid; // a pop may land here
	endproperty
	a_adc_bypass: assert property (p_adc_bypass)
		else $error("converter request not forwarded at zero wait");

	property p_seq_after_cpu;
		@(posedge mclk) disable iff (!resetn)
		(finish && !owner_seq_reg && buf_valid) |=>
		    ##1 (state_reg == ST_BUSY && owner_seq_reg);
	endproperty
	a_seq_after_cpu: assert property (p_seq_after_cpu)
		else $error("buffered access not run after cpu access");

	property p_no_preempt;
		@(posedge mclk) disable iff (!resetn)
		(state_reg == ST_BUSY && cnt_reg != WAIT_N0) |=>
		    (state_reg == ST_BUSY && $stable(owner_seq_reg) &&
		    $stable(bus_cmd));
	endproperty
	a_no_preempt: assert property (p_no_preempt)
		else $error("access pre-empted before completion");

endmodule
`default_nettype wire

// File: rtl/cluster_bus_pkg.sv
// constants, carriers and address decode for the cluster bus arbiter
// assumes a 20-bit cluster address space and 32-bit data words
package cluster_bus_pkg;

	// --------------------------------------------------------------
	// widths and buffer depth
	// --------------------------------------------------------------
	localparam int ADDR_W = 20;
	localparam int DATA_W = 32;
	localparam int BUF_DEPTH = 2;
	localparam int CNT_W = 4;

	// --------------------------------------------------------------
	// wait cycles per target class
	// --------------------------------------------------------------
	localparam logic [CNT_W-1:0] WAIT_N0 = 4'h0;
	localparam logic [CNT_W-1:0] WAIT_N1 = 4'h1;
	localparam logic [CNT_W-1:0] WAIT_MEM = 4'h2;

	// --------------------------------------------------------------
	// address map: region nibble in addr[19:16]
	// --------------------------------------------------------------
	localparam logic [3:0] REG_ADC = 4'hF;
	localparam logic [3:0] REG_FIFO_MEM = 4'hE;
	localparam logic [3:0] REG_SEQ_MEM = 4'hD;
	localparam logic [3:0] REG_PLL_RAM = 4'hC;
	localparam logic [3:0] REG_FIFO_WIN = 4'hB;
	// single-wait control registers in region 0
	localparam logic [ADDR_W-1:0] A_GLOBAL_RESET = 20'h0_0000;
	localparam logic [ADDR_W-1:0] A_CLUSTER_CLOCK_CFG = 20'h0_0004;
	localparam logic [ADDR_W-1:0] A_MODULE_RESET = 20'h0_0008;
	localparam logic [ADDR_W-1:0] A_OUTPUT_GLOBAL_CTRL = 20'h0_0010;
	localparam logic [ADDR_W-1:0] A_ADV_OUTPUT_GLOBAL_CTRL = 20'h0_0014;
	localparam logic [ADDR_W-1:0] A_ANGLE_PLL_CTRL_SECOND = 20'h0_0018;
	// trigger registers, multi-wait
	localparam logic [ADDR_W-1:0] A_TRIGGER_SET = 20'h0_0020;
	localparam logic [ADDR_W-1:0] A_TRIGGER_CLEAR = 20'h0_0024;

	// --------------------------------------------------------------
	// types
	// --------------------------------------------------------------
	typedef enum logic [1:0] {CLS_N0, CLS_N1, CLS_MEM, CLS_ADC} access_class_t;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic wr;
		logic [DATA_W-1:0] wdata;
	} bus_req_t;

	// --------------------------------------------------------------
	// decode helpers
	// --------------------------------------------------------------
	function automatic access_class_t classify(input logic [ADDR_W-1:0] a);
		access_class_t c;
		c = CLS_N0;
		unique case (a[19:16])
			REG_ADC: c = CLS_ADC;
			REG_FIFO_MEM, REG_SEQ_MEM, REG_PLL_RAM, REG_FIFO_WIN: c = CLS_MEM;
			default: begin
				if (a == A_TRIGGER_SET || a == A_TRIGGER_CLEAR)
					c = CLS_MEM;
				else if (a == A_GLOBAL_RESET || a == A_CLUSTER_CLOCK_CFG ||
				    a == A_MODULE_RESET || a == A_OUTPUT_GLOBAL_CTRL ||
				    a == A_ADV_OUTPUT_GLOBAL_CTRL ||
				    a == A_ANGLE_PLL_CTRL_SECOND)
					c = CLS_N1;
			end
		endcase
		return c;
	endfunction

	function automatic logic [CNT_W-1:0] wait_of(input access_class_t c);
		logic [CNT_W-1:0] w;
		w = WAIT_N0;
		if (c == CLS_N1)
			w = WAIT_N1;
		else if (c == CLS_MEM)
			w = WAIT_MEM;
		return w;
	endfunction

	function automatic logic seq_forbidden(input logic [ADDR_W-1:0] a);
		return (a[19:16] == REG_FIFO_MEM) || (a[19:16] == REG_SEQ_MEM);
	endfunction

endpackage

// File: rtl/sequencer_master_buffer.sv
// request buffer of the sequencer bus master
// assumes the arbiter pops the head only while it reads as valid
`timescale 1ns/1ps
`default_nettype none
module sequencer_master_buffer
	import cluster_bus_pkg::*;
(
	input wire logic mclk,
	input wire logic resetn,
	input wire logic in_valid,
	input wire cluster_bus_pkg::bus_req_t in_data,
	input wire logic in_block,
	output logic in_ready,
	output logic out_valid,
	output cluster_bus_pkg::bus_req_t out_data,
	input wire logic out_pop
);
	import cluster_bus_pkg::*;

	bus_req_t mem_reg [BUF_DEPTH];
	bus_req_t mem_next [BUF_DEPTH];
	logic [1:0] cnt_reg, cnt_next;
	logic ready_reg, ready_next;
	logic push;

	// ----------------------------------------------------------
	// shift-register queue, head at entry 0
	// ----------------------------------------------------------
	always_comb begin
		push = in_valid && ready_reg;
		mem_next = mem_reg;
		cnt_next = cnt_reg;
		if (out_pop) begin
			mem_next[0] = mem_reg[1];
			cnt_next = cnt_next - 2'h1;
		end
		if (push) begin
			mem_next[cnt_next[0]] = in_data;
			cnt_next = cnt_next + 2'h1;
		end
		// ready is registered, so it looks one cycle ahead at the next count
		ready_next = !in_block && (cnt_next < 2'(BUF_DEPTH));
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			for (int i = 0; i < BUF_DEPTH; i++)
				mem_reg[i] <= '0;
			cnt_reg <= 2'h0;
			ready_reg <= 1'b0;
		end else begin
			mem_reg <= mem_next;
			cnt_reg <= cnt_next;
			ready_reg <= ready_next;
		end
	end

	assign in_ready = ready_reg;
	assign out_valid = (cnt_reg != 2'h0);
	assign out_data = mem_reg[0];

endmodule
`default_nettype wire

// File: verification/cluster_target_model.sv
// far side of the arbiter: cluster bus targets and the converter
// assumes the arbiter holds command and address while selected
`timescale 1ns/1ps
`default_nettype none
module cluster_target_model
	import cluster_bus_pkg::*;
(
	input wire logic mclk,
	input wire logic resetn,
	input wire logic bus_sel,
	input wire cluster_bus_pkg::bus_req_t bus_cmd,
	output logic [cluster_bus_pkg::DATA_W-1:0] bus_rdata,
	input wire logic adc_sel,
	input wire logic [cluster_bus_pkg::ADDR_W-1:0] adc_addr,
	output logic [cluster_bus_pkg::DATA_W-1:0] adc_rdata
);
	import cluster_bus_pkg::*;
	logic [DATA_W-1:0] bus_last_reg;
	logic [DATA_W-1:0] adc_last_reg;

	// remember the last word so idle lines can show its inverse
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			bus_last_reg <= 32'h0000_0000;
			adc_last_reg <= 32'h0000_0000;
		end else begin
			bus_last_reg <= bus_rdata;
			adc_last_reg <= adc_rdata;
		end
	end

	// idle lines toggle every cycle, so a stale sample never passes
	always_comb begin
		// echo folds in write flag and data, so the whole command is seen
		bus_rdata = bus_sel ? ({12'hA5A, bus_cmd.addr} ^ bus_cmd.wdata ^
		    {bus_cmd.wr, 31'h0}) : ~bus_last_reg;
		adc_rdata = adc_sel ? {12'h5C3, adc_addr} : ~adc_last_reg;
	end
endmodule
`default_nettype wire

// File: verification/cluster_bus_master_arbiter_tb.sv
// self-checking bench for the cluster bus arbiter
// assumes cluster_target_model answers bus and converter accesses
`timescale 1ns/1ps
`default_nettype none
module cluster_bus_master_arbiter_tb;
	import cluster_bus_pkg::*;

	typedef struct {
		logic [1:0] kind;
		logic err;
		logic [DATA_W-1:0] data;
		int lo;
		int hi;
	} note_t;

	logic mclk, resetn, sequencer_master_disable, cpu_req, cpu_done;
	logic seq_valid, seq_ready, seq_resp_valid, seq_resp_err;
	logic seq_adc_valid, bus_sel, adc_sel;
	bus_req_t cpu_cmd, seq_cmd, bus_cmd;
	logic [DATA_W-1:0] cpu_rdata, seq_resp_rdata, seq_adc_rdata;
	logic [DATA_W-1:0] bus_rdata, adc_rdata;
	logic [ADDR_W-1:0] adc_addr;
	note_t notes[$];
	int failures = 0;
	int num_checks = 0;
	int cyc = 0;
	// target table with wait cycles; E and D refused to the sequencer
	logic [ADDR_W-1:0] amap[13] = '{A_GLOBAL_RESET, A_CLUSTER_CLOCK_CFG,
		A_MODULE_RESET, A_OUTPUT_GLOBAL_CTRL, A_ADV_OUTPUT_GLOBAL_CTRL,
		A_ANGLE_PLL_CTRL_SECOND, A_TRIGGER_SET, A_TRIGGER_CLEAR,
		20'hE_0010, 20'hD_0020, 20'hC_0030, 20'hB_0040, 20'h0_0030};
	int wmap[13] = '{1, 1, 1, 1, 1, 1, 2, 2, 2, 2, 2, 2, 0};

	cluster_bus_master_arbiter i_dut (.mclk(mclk), .resetn(resetn),
		.sequencer_master_disable(sequencer_master_disable),
		.cpu_req(cpu_req), .cpu_cmd(cpu_cmd), .cpu_done(cpu_done),
		.cpu_rdata(cpu_rdata), .seq_valid(seq_valid), .seq_cmd(seq_cmd),
		.seq_ready(seq_ready), .seq_resp_valid(seq_resp_valid),
		.seq_resp_err(seq_resp_err), .seq_resp_rdata(seq_resp_rdata),
		.seq_adc_valid(seq_adc_valid), .seq_adc_rdata(seq_adc_rdata),
		.bus_sel(bus_sel), .bus_cmd(bus_cmd), .bus_rdata(bus_rdata),
		.adc_sel(adc_sel), .adc_addr(adc_addr), .adc_rdata(adc_rdata));

	cluster_target_model i_target (.mclk(mclk), .resetn(resetn),
		.bus_sel(bus_sel), .bus_cmd(bus_cmd), .bus_rdata(bus_rdata),
		.adc_sel(adc_sel), .adc_addr(adc_addr), .adc_rdata(adc_rdata));

	// --------------------------------------------------------------
	// clock, cycle count and shared tasks
	// --------------------------------------------------------------
	initial begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end
	always @(posedge mclk) cyc <= cyc + 1;

	task automatic check(input logic [DATA_W:0] seen,
		input logic [DATA_W:0] exp, input string what);
		num_checks++;
		if (seen !== exp) begin
			failures++;
			$display("BAD %0t %s: seen %h expected %h", $time, what, seen, exp);
		end
	endtask

	task automatic print_verdict();
		if (failures == 0 && num_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// oldest note of the same kind; latency window checks the order
	task automatic take(input logic [1:0] k, input logic e,
		input logic [DATA_W-1:0] d);
		int i;
		note_t n;
		i = 0;
		while (i < notes.size() && notes[i].kind != k) i++;
		if (i == notes.size()) begin
			check(1'b1, 1'b0, "unexpected answer");
			return;
		end
		n = notes[i];
		notes.delete(i);
		check({e, d}, {n.err, n.data}, "answer");
		check(cyc >= n.lo && cyc <= n.hi, 1'b1, "cycle");
	endtask

	// sampled mid-cycle, where registered outputs have settled
	always @(negedge mclk) begin
		if (cpu_done === 1'b1) take(2'd0, 1'b0, cpu_rdata);
		if (seq_resp_valid === 1'b1) take(2'd1, seq_resp_err, seq_resp_rdata);
		if (seq_adc_valid === 1'b1) take(2'd2, 1'b0, seq_adc_rdata);
	end

	// request held with its command until done, dropped in that cycle
	task automatic cpu_acc(input logic [ADDR_W-1:0] a, input int lo,
		input int hi);
		int n = 0;
		logic [DATA_W-1:0] d;
		@(posedge mclk);
		#1;
		cpu_cmd = {a, 1'($urandom), 32'($urandom)};
		cpu_req = 1'b1;
		// the target echo folds in write flag and data
		d = {12'hA5A, a} ^ cpu_cmd.wdata ^ {cpu_cmd.wr, 31'h0};
		notes.push_back('{2'd0, 1'b0, d, cyc + lo, cyc + hi});
		while (cpu_done !== 1'b1 && n < 60) begin
			@(posedge mclk);
			#1;
			n++;
		end
		cpu_req = 1'b0;
	endtask

	// one-cycle strobe; want low means no answer may come
	task automatic seq_acc(input logic [ADDR_W-1:0] a, input int lo,
		input int hi, input logic want);
		logic [DATA_W-1:0] d;
		@(posedge mclk);
		#1;
		seq_cmd = {a, 1'($urandom), 32'($urandom)};
		seq_valid = 1'b1;
		d = {12'hA5A, a} ^ seq_cmd.wdata ^ {seq_cmd.wr, 31'h0};
		if (want && a[19:16] == REG_ADC)
			notes.push_back('{2'd2, 1'b0, {12'h5C3, a}, cyc + lo, cyc + hi});
		else if (want) begin
			check(seq_ready, 1'b1, "ready");
			if (a[19:16] == REG_FIFO_MEM || a[19:16] == REG_SEQ_MEM)
				notes.push_back('{2'd1, 1'b1, 32'h0000_0000, cyc + 3, cyc + 3});
			else
				notes.push_back('{2'd1, 1'b0, d, cyc + lo, cyc + hi});
		end
		@(posedge mclk);
		#1;
		seq_valid = 1'b0;
	endtask

	// waits up to 40 cycles for every expected answer, then flags any still missing
	task automatic drain();
		repeat (40) if (notes.size() != 0) @(posedge mclk);
		check(notes.size() == 0, 1'b1, "missing answer");
	endtask

	// --------------------------------------------------------------
	// scenarios
	// --------------------------------------------------------------
	initial begin
		resetn = 1'b0;
		sequencer_master_disable = 1'b0;
		cpu_req = 1'b0;
		seq_valid = 1'b0;
		cpu_cmd = '0;
		seq_cmd = '0;
		void'($urandom(96296));
		repeat (12) @(posedge mclk);
		#1;
		resetn = 1'b1;
		// every wait class from both masters
		foreach (amap[i]) begin
			cpu_acc(amap[i], 2 + wmap[i], 2 + wmap[i]);
			seq_acc(amap[i], 3 + wmap[i], 3 + wmap[i], 1'b1);
			drain();
		end
		// random zero-wait traffic and converter reads
		repeat (8) begin
			cpu_acc({4'(1 + $urandom % 10), 16'($urandom)}, 2, 2);
			seq_acc({4'(1 + $urandom % 10), 16'($urandom)}, 3, 3, 1'b1);
			seq_acc({REG_ADC, 16'($urandom)}, 2, 2, 1'b1);
			drain();
		end
		// converter bypasses a long cpu access
		fork
			cpu_acc(20'hC_0100, 4, 4);
			begin
				@(posedge mclk);
				seq_acc({REG_ADC, 16'h0200}, 2, 2, 1'b1);
			end
		join
		drain();
		// buffered sequencer access beats the next cpu request
		fork
			begin
				cpu_acc(20'hC_0040, 4, 4);
				cpu_acc(20'h1_0100, 3, 3);
			end
			begin
				@(posedge mclk);
				seq_acc(20'h2_0200, 5, 5, 1'b1);
			end
		join
		drain();
		// cpu and buffered sequencer request meet at the same idle slot
		fork
			seq_acc(20'hC_0050, 5, 5, 1'b1);
			begin
				repeat (2) @(posedge mclk);
				seq_acc(20'h3_0010, 5, 5, 1'b1);
			end
			begin
				repeat (2) @(posedge mclk);
				cpu_acc(20'h4_0040, 7, 7);
			end
		join
		drain();
		// permanent switch-off: converter and bus requests dropped
		@(posedge mclk);
		#1;
		sequencer_master_disable = 1'b1;
		seq_acc({REG_ADC, 16'h0300}, 0, 0, 1'b0);
		seq_acc(20'h3_0300, 0, 0, 1'b0);
		cpu_acc(20'h4_0400, 2, 2);
		drain();
		repeat (6) @(posedge mclk);
		print_verdict();
	end

	// hang guard, far beyond the few hundred cycles the run needs
	initial begin
		#(8 * 5000);
		failures++;
		print_verdict();
	end
endmodule
`default_nettype wire
